// >>> tecu_pkg.sv
// package: mode encodings, widths and state for the edge capture unit
package tecu_pkg;
    localparam int TECU_TB_W = 16;
    localparam int TECU_MODE_W = 4;
    localparam int TECU_PS_W = 4;
    localparam logic [3:0] TECU_MODE_OFF = 4'h0;
    localparam logic [3:0] TECU_MODE_FALL = 4'h4;
    localparam logic [3:0] TECU_MODE_RISE = 4'h5;
    localparam logic [3:0] TECU_MODE_RISE4 = 4'h6;
    localparam logic [3:0] TECU_MODE_RISE16 = 4'h7;
    localparam logic [3:0] TECU_PS_LAST4 = 4'h3;
    localparam logic [3:0] TECU_PS_LAST16 = 4'hF;
    localparam logic [3:0] TECU_PS_RST = 4'h0;
    localparam logic [15:0] TECU_HOLD_RST = 16'h0000;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } tecu_word_s;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic [3:0] prescale;
        tecu_word_s hold;
        logic flag;
    } tecu_state_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } tecu_edge_s;
endpackage : tecu_pkg

// >>> tecu_sync_edge.sv
// pin synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module tecu_sync_edge
    import tecu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_pin,
    output var tecu_edge_s o_edge
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        tecu_edge_s edge_out;
    } tecu_se_s;

    tecu_se_s st_reg;
    tecu_se_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = i_pin;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.edge_out.rise = st_reg.s2 & ~st_reg.s3;
        st_next.edge_out.fall = ~st_reg.s2 & st_reg.s3;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_edge = st_reg.edge_out;
endmodule : tecu_sync_edge
`default_nettype wire

// >>> tecu_capture.sv
// capture channel: copies the timebase on a selected pin event
// How it works
// - each qualifying event copies the full 16-bit timebase into the hold pair
// - mode field picks falling, rising, every 4th or every 16th rising edge
// - every capture sets the event flag; only software or reset clears it
// - a new capture simply overwrites the previous held value
// - prescaler counter held at zero when off or not in capture mode
// - any reset clears the prescaler counter
// - changing prescale choice while capturing keeps the counter value
// - edge detector watches the pin level regardless of pin direction
// - one parameterised module, instantiated once per channel
`timescale 1ns/100ps
`default_nettype none
module tecu_capture
    import tecu_pkg::*;
#(
    parameter int TB_W = TECU_TB_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_capture_input_pin,
    input wire logic [TECU_MODE_W-1:0] i_capture_mode_select,
    input wire logic [TB_W-1:0] i_capture_timebase,
    input wire logic i_flag_clear,
    output logic [7:0] o_capture_hold_high,
    output logic [7:0] o_capture_hold_low,
    output logic o_capture_event_flag,
    output logic o_capture_strobe
);
    typedef struct packed {
        logic [TECU_PS_W-1:0] prescale;
        tecu_word_s hold;
        logic flag;
        logic strobe;
    } tecu_cap_s;

    tecu_cap_s st_reg;
    tecu_cap_s st_next;
    tecu_edge_s pin_edge;
    logic capture_mode;
    logic fire;

    ////////////////////////////////////////////////////////////////
    // pin level watched whatever the pin direction
    tecu_sync_edge u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_capture_input_pin),
        .o_edge(pin_edge)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        capture_mode = 1'b1;
        fire = 1'b0;
        case (i_capture_mode_select)
            TECU_MODE_FALL: begin
                fire = pin_edge.fall;
            end
            TECU_MODE_RISE: begin
                fire = pin_edge.rise;
            end
            TECU_MODE_RISE4: begin
                fire = pin_edge.rise && (st_reg.prescale[1:0] == TECU_PS_LAST4[1:0]);
            end
            TECU_MODE_RISE16: begin
                fire = pin_edge.rise && (st_reg.prescale == TECU_PS_LAST16);
            end
            default: begin
                capture_mode = 1'b0;
            end
        endcase
        // counter survives a prescale change inside capture mode
        if (!capture_mode) begin
            st_next.prescale = TECU_PS_RST;
        end else if (pin_edge.rise) begin
            st_next.prescale = st_reg.prescale + 4'h1;
        end
        if (fire) begin
            st_next.hold = i_capture_timebase[15:0];
        end
        // set wins over a same-cycle clear
        if (fire) begin
            st_next.flag = 1'b1;
        end else if (i_flag_clear) begin
            st_next.flag = 1'b0;
        end
        st_next.strobe = fire;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg.prescale <= TECU_PS_RST;
            st_reg.hold <= TECU_HOLD_RST;
            st_reg.flag <= 1'b0;
            st_reg.strobe <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_capture_hold_high = st_reg.hold.high;
    assign o_capture_hold_low = st_reg.hold.low;
    assign o_capture_event_flag = st_reg.flag;
    assign o_capture_strobe = st_reg.strobe;
endmodule : tecu_capture
`default_nettype wire

// >>> tecu_pin_model.sv
// pin source model: one pulse on the capture pin per request
`timescale 1ns/100ps
`default_nettype none
module tecu_pin_model (
    input wire logic i_clk,
    input wire logic i_fire,
    output logic o_pin
);
    logic [1:0] cnt_reg = 2'h0;
    initial o_pin = 1'b0;
    always @(posedge i_clk) begin
        if (i_fire) cnt_reg <= 2'h3;
        else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
        o_pin <= i_fire || cnt_reg > 2'h1;
    end
endmodule : tecu_pin_model
`default_nettype wire

// >>> tecu_capture_properties.sv
// checker: capture timing, hold and flag
`timescale 1ns/100ps
`default_nettype none
module tecu_capture_properties
    import tecu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_capture_input_pin,
    input wire logic [3:0] i_capture_mode_select,
    input wire logic [15:0] i_capture_timebase,
    input wire logic i_flag_clear,
    input wire logic [7:0] o_capture_hold_high,
    input wire logic [7:0] o_capture_hold_low,
    input wire logic o_capture_event_flag,
    input wire logic o_capture_strobe
);
    wire logic s = o_capture_strobe;
    wire logic f = o_capture_event_flag;
    wire logic [3:0] m = i_capture_mode_select;
    wire logic [15:0] h = {o_capture_hold_high, o_capture_hold_low};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence rise_ev;
        $rose(i_capture_input_pin) && m == TECU_MODE_RISE ##1 (m == TECU_MODE_RISE) [*3];
    endsequence
    ////////////////////////////////
    flag_on_capture_a: assert property (s |-> f) else $error("flag");
    hold_is_time_a: assert property (s |-> h == $past(i_capture_timebase)) else $error("hold");
    strobe_single_a: assert property (s |=> !s) else $error("strobe");
    hold_kept_a: assert property (!s |-> $stable(h)) else $error("kept");
    flag_sticky_a: assert property (f && !i_flag_clear |=> f) else $error("sticky");
    flag_clear_a: assert property (i_flag_clear |=> s || !f) else $error("clear");
    off_quiet_a: assert property (m[3:2] != 2'b01 |=> !s) else $error("off");
    rise_fire_a: assert property (rise_ev |-> ##1 s) else $error("rise");
endmodule : tecu_capture_properties
bind tecu_capture tecu_capture_properties u_props (.*);
`default_nettype wire

// >>> tb_top.sv
// testbench: capture modes, prescaler and reset
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import tecu_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, fire = 1'b0, clr = 1'b0;
    logic [3:0] mode = TECU_MODE_OFF;
    logic [15:0] tbase = 16'h0000;
    logic [7:0] n_strb = 8'h00;
    logic [7:0] hh, hl;
    logic [15:0] hold_exp = 16'h0000;
    logic pin, flag, strb;
    int n_mismatch = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) tbase <= tbase + 16'h0001;
    // timebase one edge before the strobe is the value the hold pair must show
    always @(posedge clk) if (strb) hold_exp <= tbase - 16'h0001;
    always @(posedge clk) if (strb) n_strb <= n_strb + 8'h01;
    tecu_pin_model u_pin (.i_clk(clk), .i_fire(fire), .o_pin(pin));
    tecu_capture DUT (.i_clk(clk), .i_arst_n(rst_n), .i_capture_input_pin(pin), .i_capture_mode_select(mode),
        .i_capture_timebase(tbase), .i_flag_clear(clr), .o_capture_hold_high(hh), .o_capture_hold_low(hl),
        .o_capture_event_flag(flag), .o_capture_strobe(strb));
    ////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic run(input logic [3:0] md, input int n, input logic [7:0] exp, input bit off);
        logic [7:0] base;
        if (off) @(posedge clk) mode <= TECU_MODE_OFF;
        @(posedge clk) mode <= md;
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        base = n_strb;
        repeat (n) begin
            @(posedge clk) fire <= 1'b1;
            @(posedge clk) fire <= 1'b0;
            repeat (10) @(posedge clk);
        end
        chk("strobes", exp, n_strb - base);
        chk("flag", {7'h00, exp != 8'h00}, {7'h00, flag});
        if (exp != 8'h00) begin
            chk("hold_high", hold_exp[15:8], hh);
            chk("hold_low", hold_exp[7:0], hl);
        end
        $display("test mode %h done", md);
    endtask : run
    task automatic reset_mid;
        run(TECU_MODE_RISE4, 3, 8'h00, 1'b1);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        chk("hold_high", 8'h00, hh);
        chk("hold_low", 8'h00, hl);
        run(TECU_MODE_RISE4, 1, 8'h00, 1'b0);
    endtask : reset_mid
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        run(TECU_MODE_FALL, 3, 8'h03, 1'b1);
        run(TECU_MODE_RISE, 3, 8'h03, 1'b1);
        run(TECU_MODE_RISE4, 8, 8'h02, 1'b1);
        run(TECU_MODE_RISE16, 16, 8'h01, 1'b1);
        run(TECU_MODE_OFF, 4, 8'h00, 1'b1);
        run(TECU_MODE_RISE4, 2, 8'h00, 1'b1);
        run(TECU_MODE_RISE16, 14, 8'h01, 1'b0);
        reset_mid();
        tally_and_finish();
    end
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
